// [ccc_core.sv]
// instruction executor for call, clear, complement and decrement ops
//
// Operation
// - direct call pushes pc plus one first
// - direct call loads 11-bit operand into pc[10:0]
// - direct call fills pc[14:11] from latch[6:3]
// - direct call takes two cycles, flags untouched
// - indirect call loads accumulator and latch[6:0]
// - indirect call pushes, two cycles, flags untouched
// - watchdog kick clears counter and prescaler
// - watchdog kick sets timeout and power-down flags
// - invert file, destination bit picks target
// - zero file clears register, sets zero flag
// - decrement file, destination bit picks target
// - zero accumulator clears it, sets zero flag
//
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/100ps
module ccc_core (
	// clock, reset, enable
	input  wire logic                        pclk,
	input  wire logic                        presetn,
	input  wire logic                        ce,
	// apb slave
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	// core state
	output logic                             busy,
	output logic      [ccc_pkg::PC_W-1:0]    pc,
	output ccc_pkg::ccc_flags_t              flags
);
	import ccc_pkg::*;

	ccc_state_t         state_reg;
	ccc_instr_t         instr_reg;
	logic [PC_W-1:0]    pc_reg;
	logic [ACC_W-1:0]   acc_reg;
	logic [LATCH_W-1:0] latch_reg;
	logic [FILE_AW-1:0] faddr_reg;
	ccc_flags_t         flags_reg;
	logic [WDT_W-1:0]   wdt_cnt_reg;
	logic [WDT_W-1:0]   wdt_pre_reg;
	logic               rd_done_reg;
	logic [31:0]        prdata_reg;

	logic               idle;
	logic               access;
	logic               wr_take;
	logic               rd_cap;
	logic               exec;
	logic [FILE_AW-1:0] op_faddr;
	logic [ACC_W-1:0]   op_fdata;
	logic [ACC_W-1:0]   sw_fdata;
	logic [ACC_W-1:0]   alu_res;
	logic               file_we;
	logic [FILE_AW-1:0] file_waddr;
	logic [ACC_W-1:0]   file_wdata;
	logic               push;
	logic [PC_W-1:0]    stack_top;
	logic [STACK_AW-1:0] depth;
	logic [31:0]        rd_mux;
	logic               wdt_wrap;

	// register select on word address
	function automatic logic hit(input logic [7:0] a,
		input logic [7:0] off);
		hit = (a[7:2] == off[7:2]);
	endfunction

	// true for any mapped word
	function automatic logic mapped(input logic [7:0] a);
		mapped = hit(a, OFF_CMD) | hit(a, OFF_ACC) |
			hit(a, OFF_LATCH) | hit(a, OFF_PC) |
			hit(a, OFF_STATUS) | hit(a, OFF_STACK) |
			hit(a, OFF_FADDR) | hit(a, OFF_FDATA) |
			hit(a, OFF_WDT);
	endfunction

	// zero test of an 8-bit result
	function automatic logic is_zero(input logic [ACC_W-1:0] v);
		is_zero = (v == ACC_ZERO);
	endfunction

	// bus handshake terms
	assign idle    = (state_reg == ST_IDLE);
	assign access  = psel & penable;
	assign pready  = ce & idle & (pwrite | rd_done_reg);
	assign pslverr = access & pready & ~mapped(paddr);
	assign wr_take = access & pwrite & pready;
	assign rd_cap  = ce & access & ~pwrite & idle & ~rd_done_reg;
	assign prdata  = prdata_reg;

	// status outputs
	assign busy  = ~idle;
	assign pc    = pc_reg;
	assign flags = flags_reg;

	// one execution cycle of the latched instruction
	assign exec     = ce & (state_reg == ST_EXEC);
	assign op_faddr = instr_reg.operand[FILE_AW-1:0];

	// invert or decrement of the addressed file register
	always_comb begin
		alu_res = ACC_ZERO;
		if (instr_reg.op == OP_INVERT_FILE) begin
			alu_res = ~op_fdata;
		end else if (instr_reg.op == OP_DECREMENT_FILE) begin
			alu_res = op_fdata - ACC_ONE;
		end
	end

	// file write: instruction result or software data
	always_comb begin
		file_we    = 1'b0;
		file_waddr = faddr_reg;
		file_wdata = pwdata[ACC_W-1:0];
		if (exec) begin
			file_waddr = op_faddr;
			case (instr_reg.op)
				// zero file clears the target
				// clear file register
				OP_ZERO_FILE: begin
					file_we    = 1'b1;
					file_wdata = ACC_ZERO;
				end
				OP_INVERT_FILE: begin
					file_we    = instr_reg.dest;
					file_wdata = alu_res;
				end
				OP_DECREMENT_FILE: begin
					file_we    = instr_reg.dest;
					file_wdata = alu_res;
				end
				default: begin
					file_we = 1'b0;
				end
			endcase
		end else if (wr_take && hit(paddr, OFF_FDATA)) begin
			file_we = 1'b1;
		end
	end

	ccc_file_regs u_file (
		.pclk    (pclk),
		.ce      (ce),
		.we      (file_we),
		.waddr   (file_waddr),
		.wdata   (file_wdata),
		.raddr_a (op_faddr),
		.rdata_a (op_fdata),
		.raddr_b (faddr_reg),
		.rdata_b (sw_fdata)
	);

	assign push = exec & ((instr_reg.op == OP_DIRECT_CALL) |
		(instr_reg.op == OP_INDIRECT_CALL));

	ccc_stack u_stack (
		.pclk      (pclk),
		.presetn   (presetn),
		.ce        (ce),
		.push      (push),
		.push_data (pc_reg + 1'b1),
		.stack_top (stack_top),
		.depth     (depth)
	);

	// sequencer: command write starts, calls take a second cycle
	// two-cycle call sequence
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_IDLE;
			instr_reg <= '0;
		end else if (ce) begin
			case (state_reg)
				ST_IDLE: begin
					if (wr_take && hit(paddr, OFF_CMD) &&
						pwdata[CMD_OP_LSB +: OP_W] != OP_NONE) begin
						instr_reg.op <=
							ccc_op_t'(pwdata[CMD_OP_LSB +: OP_W]);
						instr_reg.dest    <= pwdata[CMD_DEST];
						instr_reg.operand <= pwdata[CMD_K_LSB +: K_W];
						state_reg <= ST_EXEC;
					end
				end
				ST_EXEC: begin
					if (push) begin
						state_reg <= ST_CALL2;
					end else begin
						state_reg <= ST_IDLE;
					end
				end
				ST_CALL2: begin
					state_reg <= ST_IDLE;
				end
				default: begin
					state_reg <= ST_IDLE;
				end
			endcase
		end
	end

	// program counter: loaded in the second call cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pc_reg <= RST_PC;
		end else if (ce && state_reg == ST_CALL2) begin
			if (instr_reg.op == OP_DIRECT_CALL) begin
				pc_reg[K_W-1:0] <= instr_reg.operand;
				pc_reg[PC_W-1:K_W] <=
					latch_reg[LATCH_DIR_HI:LATCH_DIR_LO];
			end else begin
				pc_reg <= {latch_reg, acc_reg};
			end
		end else if (wr_take && hit(paddr, OFF_PC)) begin
			pc_reg <= pwdata[PC_W-1:0];
		end
	end

	// accumulator: instruction targets or software write
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acc_reg <= RST_ACC;
		end else if (exec) begin
			if (instr_reg.op == OP_ZERO_ACC) begin
				acc_reg <= ACC_ZERO;
			end else if (!instr_reg.dest &&
				(instr_reg.op == OP_INVERT_FILE ||
				instr_reg.op == OP_DECREMENT_FILE)) begin
				acc_reg <= alu_res;
			end
		end else if (wr_take && hit(paddr, OFF_ACC)) begin
			acc_reg <= pwdata[ACC_W-1:0];
		end
	end

	// jump latch and file address, software only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			latch_reg <= RST_LATCH;
			faddr_reg <= '0;
		end else if (wr_take) begin
			if (hit(paddr, OFF_LATCH)) begin
				latch_reg <= pwdata[LATCH_W-1:0];
			end else if (hit(paddr, OFF_FADDR)) begin
				faddr_reg <= pwdata[FILE_AW-1:0];
			end
		end
	end

	// watchdog prescaler and counter, wrap of both is a timeout
	assign wdt_wrap = (wdt_pre_reg == WDT_MAX) &
		(wdt_cnt_reg == WDT_MAX);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_pre_reg <= WDT_ZERO;
			wdt_cnt_reg <= WDT_ZERO;
		end else if (exec && instr_reg.op == OP_WATCHDOG_KICK) begin
			wdt_pre_reg <= WDT_ZERO;
			wdt_cnt_reg <= WDT_ZERO;
		end else if (ce) begin
			wdt_pre_reg <= wdt_pre_reg + 1'b1;
			if (wdt_pre_reg == WDT_MAX) begin
				wdt_cnt_reg <= wdt_cnt_reg + 1'b1;
			end
		end
	end

	// status flags; calls and watchdog kick leave zero alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flags_reg.timeout_flag    <= 1'b1;
			flags_reg.power_down_flag <= 1'b1;
			flags_reg.zero            <= 1'b0;
		end else if (exec) begin
			case (instr_reg.op)
				OP_WATCHDOG_KICK: begin
					flags_reg.timeout_flag    <= 1'b1;
					flags_reg.power_down_flag <= 1'b1;
				end
				OP_ZERO_FILE: begin
					flags_reg.zero <= 1'b1;
				end
				OP_ZERO_ACC: begin
					flags_reg.zero <= 1'b1;
				end
				OP_INVERT_FILE, OP_DECREMENT_FILE: begin
					flags_reg.zero <= is_zero(alu_res);
				end
				default: begin
					flags_reg.zero <= flags_reg.zero;
				end
			endcase
			if (wdt_wrap && instr_reg.op != OP_WATCHDOG_KICK) begin
				flags_reg.timeout_flag <= 1'b0;
			end
		end else if (wr_take && hit(paddr, OFF_STATUS)) begin
			flags_reg.zero            <= pwdata[ST_ZERO];
			flags_reg.power_down_flag <= pwdata[ST_PD];
			flags_reg.timeout_flag    <= pwdata[ST_TO] & ~wdt_wrap; // wrap wins
		end else if (ce && wdt_wrap) begin
			flags_reg.timeout_flag <= 1'b0; // watchdog ran out
		end
	end

	// read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit(paddr, OFF_CMD)) begin
			rd_mux = 32'(instr_reg);
		end else if (hit(paddr, OFF_ACC)) begin
			rd_mux = 32'(acc_reg);
		end else if (hit(paddr, OFF_LATCH)) begin
			rd_mux = 32'(latch_reg);
		end else if (hit(paddr, OFF_PC)) begin
			rd_mux = 32'(pc_reg);
		end else if (hit(paddr, OFF_STATUS)) begin
			rd_mux[ST_ZERO] = flags_reg.zero;
			rd_mux[ST_PD]   = flags_reg.power_down_flag;
			rd_mux[ST_TO]   = flags_reg.timeout_flag;
		end else if (hit(paddr, OFF_STACK)) begin
			rd_mux = {12'h000, depth, 1'b0, stack_top};
		end else if (hit(paddr, OFF_FADDR)) begin
			rd_mux = 32'(faddr_reg);
		end else if (hit(paddr, OFF_FDATA)) begin
			rd_mux = 32'(sw_fdata);
		end else if (hit(paddr, OFF_WDT)) begin
			rd_mux = {16'h0000, wdt_pre_reg, wdt_cnt_reg};
		end
	end

	// read answer is captured one cycle before pready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rd_done_reg <= 1'b0;
			prdata_reg  <= 32'h0000_0000;
		end else if (ce) begin
			if (rd_cap) begin
				rd_done_reg <= 1'b1;
				prdata_reg  <= rd_mux;
			end else begin
				rd_done_reg <= 1'b0;
			end
		end
	end
endmodule

// [ccc_pkg.sv]
// constants and types shared by the call, clear and complement core ops
package ccc_pkg;
	// widths
	localparam int PC_W        = 15;
	localparam int ACC_W       = 8;
	localparam int LATCH_W     = 7;
	localparam int FILE_AW     = 7;
	localparam int FILE_DEPTH  = 128;
	localparam int STACK_AW    = 4;
	localparam int STACK_DEPTH = 16;
	localparam int WDT_W       = 8;
	localparam int K_W         = 11;
	localparam int OP_W        = 3;
	// register byte offsets
	localparam logic [7:0] OFF_CMD    = 8'h00;
	localparam logic [7:0] OFF_ACC    = 8'h04;
	localparam logic [7:0] OFF_LATCH  = 8'h08;
	localparam logic [7:0] OFF_PC     = 8'h0C;
	localparam logic [7:0] OFF_STATUS = 8'h10;
	localparam logic [7:0] OFF_STACK  = 8'h14;
	localparam logic [7:0] OFF_FADDR  = 8'h18;
	localparam logic [7:0] OFF_FDATA  = 8'h1C;
	localparam logic [7:0] OFF_WDT    = 8'h20;
	// command word fields
	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_DEST    = 3;
	localparam int CMD_K_LSB   = 4;
	// status bit positions
	localparam int ST_ZERO     = 0;
	localparam int ST_PD       = 1;
	localparam int ST_TO       = 2;
	// jump latch slice used for the upper pc bits
	localparam int LATCH_DIR_HI = 6;
	localparam int LATCH_DIR_LO = 3;
	// reset values and other constants
	localparam logic [PC_W-1:0]    RST_PC    = 15'h0000;
	localparam logic [ACC_W-1:0]   RST_ACC   = 8'h00;
	localparam logic [LATCH_W-1:0] RST_LATCH = 7'h00;
	localparam logic [WDT_W-1:0]   WDT_ZERO  = 8'h00;
	localparam logic [ACC_W-1:0]   ACC_ZERO  = 8'h00;
	localparam logic [ACC_W-1:0]   ACC_ONE   = 8'h01;
	localparam logic [WDT_W-1:0]   WDT_MAX   = 8'hFF;

	typedef enum logic [OP_W-1:0] {
		OP_NONE           = 3'h0,
		OP_DIRECT_CALL    = 3'h1,
		OP_INDIRECT_CALL  = 3'h2,
		OP_WATCHDOG_KICK  = 3'h3,
		OP_INVERT_FILE    = 3'h4,
		OP_ZERO_FILE      = 3'h5,
		OP_DECREMENT_FILE = 3'h6,
		OP_ZERO_ACC       = 3'h7
	} ccc_op_t;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'h1,
		ST_EXEC  = 3'h2,
		ST_CALL2 = 3'h4
	} ccc_state_t;

	typedef struct packed {
		ccc_op_t        op;
		logic           dest;
		logic [K_W-1:0] operand;
	} ccc_instr_t;

	typedef struct packed {
		logic timeout_flag;
		logic power_down_flag;
		logic zero;
	} ccc_flags_t;
endpackage

// [ccc_stack.sv]
// hardware return stack, push only, wraps when full
`timescale 1ns/100ps
module ccc_stack (
	// clock and reset
	input  wire logic                         pclk,
	input  wire logic                         presetn,
	input  wire logic                         ce,
	// push port
	input  wire logic                         push,
	input  wire logic [ccc_pkg::PC_W-1:0]     push_data,
	// state
	output logic      [ccc_pkg::PC_W-1:0]     stack_top,
	output logic      [ccc_pkg::STACK_AW-1:0] depth
);
	import ccc_pkg::*;

	logic [PC_W-1:0]     mem [STACK_DEPTH];
	logic [STACK_AW-1:0] ptr_reg;

	// pointer names the next free slot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ptr_reg <= '0;
		end else if (ce && push) begin
			ptr_reg <= ptr_reg + 1'b1;
		end
	end

	// entries cleared at reset so the top reads defined
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < STACK_DEPTH; i++) begin
				mem[i] <= RST_PC;
			end
		end else if (ce && push) begin
			mem[ptr_reg] <= push_data;
		end
	end

	assign stack_top = mem[ptr_reg - 1'b1];
	assign depth     = ptr_reg;
endmodule

// [ccc_file_regs.sv]
// file register array with two read ports and one write port
`timescale 1ns/100ps
module ccc_file_regs (
	// clock
	input  wire logic                        pclk,
	input  wire logic                        ce,
	// write port
	input  wire logic                        we,
	input  wire logic [ccc_pkg::FILE_AW-1:0] waddr,
	input  wire logic [ccc_pkg::ACC_W-1:0]   wdata,
	// read ports
	input  wire logic [ccc_pkg::FILE_AW-1:0] raddr_a,
	output logic      [ccc_pkg::ACC_W-1:0]   rdata_a,
	input  wire logic [ccc_pkg::FILE_AW-1:0] raddr_b,
	output logic      [ccc_pkg::ACC_W-1:0]   rdata_b
);
	import ccc_pkg::*;

	logic [ACC_W-1:0] mem [FILE_DEPTH];

	// single write per cycle, frozen with ce
	always_ff @(posedge pclk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// asynchronous reads
	assign rdata_a = mem[raddr_a];
	assign rdata_b = mem[raddr_b];
endmodule

// [ccc_core_chk.sv]
// concurrent checks on the ports of the call and clear op core
`timescale 1ns/100ps
module ccc_core_chk (
	// clock, reset, enable
	input wire logic                pclk,
	input wire logic                presetn,
	input wire logic                ce,
	// apb slave
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [31:0]         prdata,
	input wire logic                pready,
	input wire logic                pslverr,
	// core state
	input wire logic                busy,
	input wire logic [14:0]         pc,
	input wire ccc_pkg::ccc_flags_t flags
);
	import ccc_pkg::*;
	logic       cmd_wr;
	logic [2:0] op;
	// command word taken at this edge
	assign cmd_wr = psel & penable & pwrite & pready & (paddr[7:2] == 6'h00);
	assign op = pwdata[2:0];
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_dcall_low;
		cmd_wr && op == 3'h1 |-> ##3 pc[10:0] == $past(pwdata[14:4], 3);
	endproperty
	a_dcall_low: assert property (p_dcall_low)
		else $error("direct call low pc bits wrong");
	property p_dcall_len;
		cmd_wr && op == 3'h1 |=> busy [*2] ##1 !busy;
	endproperty
	a_dcall_len: assert property (p_dcall_len)
		else $error("direct call length wrong");
	property p_dcall_flags;
		cmd_wr && op == 3'h1 |-> ##3 flags == $past(flags, 3);
	endproperty
	a_dcall_flags: assert property (p_dcall_flags)
		else $error("direct call changed flags");
	property p_icall;
		cmd_wr && op == 3'h2 |=> busy [*2] ##1 (!busy && flags == $past(flags, 3));
	endproperty
	a_icall: assert property (p_icall)
		else $error("indirect call length or flags wrong");
	property p_kick;
		cmd_wr && op == 3'h3 |-> ##2 flags.timeout_flag && flags.power_down_flag;
	endproperty
	a_kick: assert property (p_kick)
		else $error("watchdog kick left a flag clear");
	property p_zfile;
		cmd_wr && op == 3'h5 |-> ##2 flags.zero;
	endproperty
	a_zfile: assert property (p_zfile)
		else $error("zero file left zero clear");
	property p_zacc;
		cmd_wr && op == 3'h7 |-> ##2 flags.zero;
	endproperty
	a_zacc: assert property (p_zacc)
		else $error("zero accumulator left zero clear");
	property p_simple;
		cmd_wr && op >= 3'h3 |=> busy ##1 (!busy && pc == $past(pc, 2));
	endproperty
	a_simple: assert property (p_simple)
		else $error("data op disturbed pc or length");
endmodule

bind ccc_core ccc_core_chk chk_u (.pclk(pclk), .presetn(presetn), .ce(ce),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.busy(busy), .pc(pc), .flags(flags));

// [testbench.sv]
// self-checking bench for the call and clear op core
`timescale 1ns/100ps
module testbench;
	import ccc_pkg::*;
	logic        pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic        busy, er, d;
	logic [7:0]  paddr, a, v, r;
	logic [31:0] pwdata, prdata, rd;
	logic [14:0] pc, pcv;
	ccc_flags_t  flags;
	logic [6:0]  l, f;
	logic [10:0] k;
	logic [2:0]  op;
	int          n_fail, total_checks, seed, cyc, dp;
	ccc_core dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy),
		.pc(pc), .flags(flags));
	// clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// expected result of a data op on file value x
	function automatic logic [7:0] exp_res(input logic [2:0] o,
		input logic [7:0] x);
		if (o == 3'h4)
			exp_res = ~x;
		else if (o == 3'h6)
			exp_res = x - 8'h01;
		else
			exp_res = 8'h00;
	endfunction
	// expected accumulator after a data op
	function automatic logic [7:0] exp_acc(input logic [2:0] o,
		input logic dd, input logic [7:0] res, input logic [7:0] old);
		exp_acc = (o == 3'h7 || (o != 3'h5 && !dd)) ? res : old;
	endfunction
	// expected file register after a data op
	function automatic logic [7:0] exp_file(input logic [2:0] o,
		input logic dd, input logic [7:0] res, input logic [7:0] old);
		exp_file = (o == 3'h5 || (o != 3'h7 && dd)) ? res : old;
	endfunction
	// one apb transfer, waits for pready
	task automatic xfer(input logic [7:0] ad, input logic w,
		input logic [31:0] wd);
		@(posedge pclk);
		psel    <= 1'b1;
		paddr   <= ad;
		pwrite  <= w;
		pwdata  <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// hang guard
	initial begin
		cyc = 0;
		forever begin
			@(posedge pclk);
			cyc++;
			if (cyc == 20000) begin
				n_fail++;
				summarize();
			end
		end
	end
	initial begin
		seed = 32'h7422;
		n_fail = 0;
		total_checks = 0;
		dp = 0;
		presetn = 1'b0;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		chk(pc, RST_PC);
		chk(flags, 3'h6);
		presetn <= 1'b1;
		// register access, unmapped read, frozen clock enable
		a = 8'($random(seed));
		l = 7'($random(seed));
		xfer(OFF_ACC, 1'b1, {24'h0, a});
		xfer(OFF_ACC, 1'b0, 32'h0);
		chk(rd, {24'h0, a});
		xfer(8'h24, 1'b0, 32'h0);
		chk(er, 1'b1);
		chk(rd, 32'h0);
		fork
			xfer(OFF_LATCH, 1'b1, {25'h0, l});
			begin
				ce <= 1'b0;
				repeat (4) @(posedge pclk);
				ce <= 1'b1;
			end
		join
		xfer(OFF_LATCH, 1'b0, 32'h0);
		chk(rd, {25'h0, l});
		// direct and indirect calls, corners first
		for (int i = 0; i < 8; i++) begin
			l = 7'($random(seed));
			k = 11'($random(seed));
			a = 8'($random(seed));
			pcv = 15'($random(seed));
			if (i < 2) begin
				l = 7'h7F;
				k = 11'h7FF;
				a = 8'hFF;
				pcv = 15'h7FFF;
			end
			op = i[0] ? 3'h2 : 3'h1;
			xfer(OFF_ACC, 1'b1, {24'h0, a});
			xfer(OFF_LATCH, 1'b1, {25'h0, l});
			xfer(OFF_PC, 1'b1, {17'h0, pcv});
			xfer(OFF_CMD, 1'b1, {17'h0, k, 1'b0, op});
			xfer(OFF_STACK, 1'b0, 32'h0);
			dp++;
			chk(rd[19:0], {dp[3:0], 1'b0, pcv + 15'h1});
			if (op == 3'h1)
				chk(pc, {l[6:3], k});
			else
				chk(pc, {l, a});
		end
		// watchdog kick after the counter has moved
		repeat (600) @(posedge pclk);
		xfer(OFF_STATUS, 1'b1, 32'h0);
		xfer(OFF_CMD, 1'b1, {29'h0, 3'h3});
		xfer(OFF_WDT, 1'b0, 32'h0);
		chk(rd[7:0], WDT_ZERO);
		chk(rd[15:12], 4'h0);
		xfer(OFF_STATUS, 1'b0, 32'h0);
		chk(rd[2:0], 3'h6);
		// data ops, both destinations, zero result corners last
		for (int i = 0; i < 12; i++) begin
			op = 3'(i % 4 + 4);
			d = i[2];
			a = 8'($random(seed));
			v = 8'($random(seed));
			f = 7'($random(seed));
			if (i >= 8)
				v = (op == 3'h4) ? 8'hFF : 8'h01;
			r = exp_res(op, v);
			xfer(OFF_ACC, 1'b1, {24'h0, a});
			xfer(OFF_STATUS, 1'b1, {31'h0, r != 8'h00});
			xfer(OFF_FADDR, 1'b1, {25'h0, f});
			xfer(OFF_FDATA, 1'b1, {24'h0, v});
			xfer(OFF_CMD, 1'b1, {21'h0, f, d, op});
			xfer(OFF_ACC, 1'b0, 32'h0);
			chk(rd, {24'h0, exp_acc(op, d, r, a)});
			xfer(OFF_FDATA, 1'b0, 32'h0);
			chk(rd, {24'h0, exp_file(op, d, r, v)});
			chk(flags.zero, r == 8'h00);
		end
		// second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(pc, RST_PC);
		chk(flags, 3'h6);
		chk(prdata, 32'h0);
		chk(busy, 1'b0);
		presetn <= 1'b1;
		// stack emptied and cleared by reset
		xfer(OFF_STACK, 1'b0, 32'h0);
		chk(rd[19:0], 20'h0);
		summarize();
	end
endmodule
